// file: rtl/cdp_params.svh
// constants for the channel divider and source prescaler block
`ifndef CDP_PARAMS_SVH
`define CDP_PARAMS_SVH

// ************************************************
// register indices (byte address is four times the index)
// ************************************************
`define CDP_IDX_DIV_CYCLES 12'h199
`define CDP_IDX_DIV_CTRL 12'h19a
`define CDP_IDX_PWR_ROUTE 12'h19b
`define CDP_IDX_PRESCALE 12'h1e0
`define CDP_IDX_SRC_SEL 12'h1e1
`define CDP_IDX_STATUS 12'h1f0

// ************************************************
// field positions
// ************************************************
`define CDP_BIT_BYPASS 7
`define CDP_BIT_IGN_SYNC 6
`define CDP_BIT_FORCE 5
`define CDP_BIT_START_HIGH 4
`define CDP_BIT_PWR_DOWN 2
`define CDP_BIT_DIRECT 1
`define CDP_BIT_DCC_OFF 0
`define CDP_BIT_SEL_OSC 1
`define CDP_BIT_PRE_BYPASS 0

// ************************************************
// reset values and encodings
// ************************************************
`define CDP_RST_DIV_CYCLES 8'h00
`define CDP_RST_DIV_CTRL 8'h00
`define CDP_RST_PWR_ROUTE 8'h00
`define CDP_RST_PRESCALE 8'h00
`define CDP_RST_SRC_SEL 8'h00
`define CDP_SEL_ROUTE_OSC 2'h2
`define CDP_SEL_ROUTE_EXT 2'h0
`define CDP_PRE_MIN_RATIO 3'h2
`define CDP_PRE_MAX_CODE 3'h4
`define CDP_PRE_MAX_RATIO 3'h6
`define CDP_DIV_EXTRA 6'h02

`endif

// file: rtl/cdp_pkg.sv
// types shared by the channel divider and source prescaler block
package cdp_pkg;

	// channel divider configuration
	typedef struct packed
	{
		logic bypass;
		logic ignore_sync;
		logic force_out;
		logic start_high;
		logic [3:0] phase;
		logic [3:0] low_cycles;
		logic [3:0] high_cycles;
		logic dcc_off;
	} cdp_div_cfg_t;

	// channel divider states
	typedef enum logic [2:0]
	{
		CDP_HOLD = 3'b001,
		CDP_DELAY = 3'b010,
		CDP_RUN = 3'b100
	} cdp_div_state_t;

endpackage

// file: rtl/cdp_divider.sv
// channel divider: counts input ticks into a divided clock level
`timescale 1ns/100ps
`default_nettype none
`include "cdp_params.svh"

module cdp_divider
(
	input wire logic clk,
	input wire logic srst,
	input wire cdp_pkg::cdp_div_cfg_t cfg,
	input wire logic in_tick,
	input wire logic in_level,
	input wire logic chip_sync,
	output logic div_out,
	output logic running
);
	import cdp_pkg::*;

	cdp_div_state_t state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic lvl_q, lvl_d;
	logic [5:0] period;
	logic [5:0] hi_n;
	logic [5:0] lo_n;
	logic sync_hold;

	// ************************************************
	// phase lengths
	// ************************************************
	// period is low plus high plus two input cycles
	assign period = {2'h0, cfg.low_cycles} + {2'h0, cfg.high_cycles} + `CDP_DIV_EXTRA;
	// correction splits the period evenly, otherwise each phase is its field plus one
	assign hi_n = cfg.dcc_off ? ({2'h0, cfg.high_cycles} + 6'h01) : (period >> 1);
	assign lo_n = period - hi_n;
	assign sync_hold = chip_sync & ~cfg.ignore_sync;

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		lvl_d = lvl_q;
		if (cfg.bypass)
		begin
			// divider idle, input passed straight through, force ignored
			lvl_d = in_level;
			state_d = CDP_HOLD;
			cnt_d = 6'h00;
		end
		else if (cfg.ignore_sync & cfg.force_out)
		begin
			// static output at the start level
			lvl_d = cfg.start_high;
			state_d = CDP_HOLD;
			cnt_d = 6'h00;
		end
		else
		begin
			case (state_q)
				CDP_HOLD:
				begin
					lvl_d = cfg.start_high;
					if (!sync_hold)
					begin
						state_d = CDP_DELAY;
						cnt_d = {2'h0, cfg.phase};
					end
				end
				CDP_DELAY:
				begin
					lvl_d = cfg.start_high;
					if (sync_hold)
						state_d = CDP_HOLD;
					else if (cnt_q == 6'h00)
					begin
						state_d = CDP_RUN;
						cnt_d = (cfg.start_high ? hi_n : lo_n) - 6'h01;
					end
					else if (in_tick)
						cnt_d = cnt_q - 6'h01;
				end
				CDP_RUN:
				begin
					if (sync_hold)
						state_d = CDP_HOLD;
					else if (in_tick)
					begin
						if (cnt_q == 6'h00)
						begin
							lvl_d = ~lvl_q;
							cnt_d = (lvl_q ? lo_n : hi_n) - 6'h01;
						end
						else
							cnt_d = cnt_q - 6'h01;
					end
				end
				default:
				begin
					state_d = CDP_HOLD;
					cnt_d = 6'h00;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= CDP_HOLD;
			cnt_q <= 6'h00;
			lvl_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign div_out = lvl_q;
	assign running = (state_q == CDP_RUN);

endmodule
`default_nettype wire

// file: rtl/cdp_channel.sv
// channel divider, source prescaler and routing with an AHB-Lite register slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_params.svh"

module cdp_channel
(
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic internal_oscillator,
	input wire logic ext_clk_in,
	input wire logic chip_sync,
	output logic group_output_a,
	output logic group_output_b,
	output logic group_output_c,
	output logic channel_powered_down
);
	import cdp_pkg::*;

	// ************************************************
	// register bus
	// ************************************************
	logic [7:0] div_cycles_q, div_cycles_d;
	logic [7:0] div_ctrl_q, div_ctrl_d;
	logic [7:0] pwr_route_q, pwr_route_d;
	logic [7:0] prescale_q, prescale_d;
	logic [7:0] src_sel_q, src_sel_d;
	logic wr_pend_q, wr_pend_d;
	logic [11:0] wr_idx_q, wr_idx_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q;
	logic hresp_q;
	logic [7:0] status;
	logic addr_ok;
	logic [11:0] rd_idx;
	logic [7:0] rd_val;
	logic rd_fwd;

	// word index of the address phase; upper bits must be zero
	assign rd_idx = haddr[13:2];
	assign addr_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);

	// register read mux, with forwarding of a write still in its data phase
	always_comb
	begin
		rd_fwd = wr_pend_q && (wr_idx_q == rd_idx);
		rd_val = 8'h00;
		if (addr_ok)
		begin
			case (rd_idx)
				`CDP_IDX_DIV_CYCLES: rd_val = rd_fwd ? hwdata[7:0] : div_cycles_q;
				`CDP_IDX_DIV_CTRL: rd_val = rd_fwd ? hwdata[7:0] : div_ctrl_q;
				`CDP_IDX_PWR_ROUTE: rd_val = rd_fwd ? {5'h00, hwdata[2:0]} : pwr_route_q;
				`CDP_IDX_PRESCALE: rd_val = rd_fwd ? {5'h00, hwdata[2:0]} : prescale_q;
				`CDP_IDX_SRC_SEL: rd_val = rd_fwd ? {6'h00, hwdata[1:0]} : src_sel_q;
				`CDP_IDX_STATUS: rd_val = status;
				default: rd_val = 8'h00;
			endcase
		end
	end

	// address phase capture and data phase write
	always_comb
	begin
		div_cycles_d = div_cycles_q;
		div_ctrl_d = div_ctrl_q;
		pwr_route_d = pwr_route_q;
		prescale_d = prescale_q;
		src_sel_d = src_sel_q;
		hrdata_d = hrdata_q;
		wr_pend_d = 1'b0;
		wr_idx_d = wr_idx_q;
		if (wr_pend_q)
		begin
			case (wr_idx_q)
				`CDP_IDX_DIV_CYCLES: div_cycles_d = hwdata[7:0];
				`CDP_IDX_DIV_CTRL: div_ctrl_d = hwdata[7:0];
				`CDP_IDX_PWR_ROUTE: pwr_route_d = {5'h00, hwdata[2:0]};
				`CDP_IDX_PRESCALE: prescale_d = {5'h00, hwdata[2:0]};
				`CDP_IDX_SRC_SEL: src_sel_d = {6'h00, hwdata[1:0]};
				default: wr_idx_d = wr_idx_q;
			endcase
		end
		if (hsel && hready && htrans[1])
		begin
			if (hwrite)
			begin
				wr_pend_d = addr_ok;
				wr_idx_d = rd_idx;
				hrdata_d = 32'h00000000;
			end
			else
				hrdata_d = {24'h000000, rd_val};
		end
	end

	// register file and bus answer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div_cycles_q <= `CDP_RST_DIV_CYCLES;
			div_ctrl_q <= `CDP_RST_DIV_CTRL;
			pwr_route_q <= `CDP_RST_PWR_ROUTE;
			prescale_q <= `CDP_RST_PRESCALE;
			src_sel_q <= `CDP_RST_SRC_SEL;
			wr_pend_q <= 1'b0;
			wr_idx_q <= 12'h000;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
		else
		begin
			div_cycles_q <= div_cycles_d;
			div_ctrl_q <= div_ctrl_d;
			pwr_route_q <= pwr_route_d;
			prescale_q <= prescale_d;
			src_sel_q <= src_sel_d;
			wr_pend_q <= wr_pend_d;
			wr_idx_q <= wr_idx_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// bus answer straight from its registers
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// ************************************************
	// source select and prescaler
	// ************************************************
	// source selection, prescaler and tick signals
	logic sel_osc;
	logic pre_bypass;
	logic src_lvl;
	logic src_prev_q;
	logic src_edge;
	logic [2:0] ratio;
	logic [2:0] pre_cnt_q, pre_cnt_d;
	logic pre_lvl_q, pre_lvl_d;
	logic pre_tick;
	logic dist_tick;
	logic dist_lvl;

	// oscillator selection forces the prescaler into use
	assign sel_osc = src_sel_q[`CDP_BIT_SEL_OSC];
	assign pre_bypass = src_sel_q[`CDP_BIT_PRE_BYPASS] & ~sel_osc;
	assign src_lvl = sel_osc ? internal_oscillator : ext_clk_in;
	assign src_edge = src_lvl & ~src_prev_q;
	// codes above the table saturate at the largest ratio
	assign ratio = (prescale_q[2:0] > `CDP_PRE_MAX_CODE) ? `CDP_PRE_MAX_RATIO :
		(prescale_q[2:0] + `CDP_PRE_MIN_RATIO);
	assign pre_tick = src_edge && (pre_cnt_q == ratio - 3'h1);
	assign dist_tick = pre_bypass ? src_edge : pre_tick;
	assign dist_lvl = pre_bypass ? src_lvl : pre_lvl_q;

	// prescaler count and divided level, high for the first half of the ratio
	always_comb
	begin
		pre_cnt_d = pre_cnt_q;
		if (src_edge)
			pre_cnt_d = pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
		pre_lvl_d = (pre_cnt_d < (ratio >> 1));
	end

	// prescaler registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			src_prev_q <= 1'b0;
			pre_cnt_q <= 3'h0;
			pre_lvl_q <= 1'b0;
		end
		else
		begin
			src_prev_q <= src_lvl;
			pre_cnt_q <= pre_cnt_d;
			pre_lvl_q <= pre_lvl_d;
		end
	end

	// ************************************************
	// channel divider
	// ************************************************
	// divider configuration and its outputs
	cdp_div_cfg_t div_cfg;
	logic div_out;
	logic div_running;

	// configuration fields gathered from the three control registers
	always_comb
	begin
		div_cfg.bypass = div_ctrl_q[`CDP_BIT_BYPASS];
		div_cfg.ignore_sync = div_ctrl_q[`CDP_BIT_IGN_SYNC];
		div_cfg.force_out = div_ctrl_q[`CDP_BIT_FORCE];
		div_cfg.start_high = div_ctrl_q[`CDP_BIT_START_HIGH];
		div_cfg.phase = div_ctrl_q[3:0];
		div_cfg.low_cycles = div_cycles_q[7:4];
		div_cfg.high_cycles = div_cycles_q[3:0];
		div_cfg.dcc_off = pwr_route_q[`CDP_BIT_DCC_OFF];
	end

	cdp_divider u_div
	(
		.clk(clk),
		.srst(srst),
		.cfg(div_cfg),
		.in_tick(dist_tick),
		.in_level(dist_lvl),
		.chip_sync(chip_sync),
		.div_out(div_out),
		.running(div_running)
	);

	// ************************************************
	// output routing
	// ************************************************
	// routing and output stage state
	logic pwr_down;
	logic route_lvl;
	logic [2:0] grp_q, grp_d;
	logic pd_q;

	// power-down bit of the routing register
	assign pwr_down = pwr_route_q[`CDP_BIT_PWR_DOWN];

	// direct routing by source-select pair, otherwise the divider
	always_comb
	begin
		route_lvl = div_out;
		if (pwr_route_q[`CDP_BIT_DIRECT])
		begin
			if (src_sel_q[1:0] == `CDP_SEL_ROUTE_OSC)
				route_lvl = internal_oscillator;
			else if (src_sel_q[1:0] == `CDP_SEL_ROUTE_EXT)
				route_lvl = ext_clk_in;
		end
	end

	// one copy per output of the group, parked low when powered down
	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_out
			assign grp_d[g] = pwr_down ? 1'b0 : route_lvl;
		end
	endgenerate

	// output registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			grp_q <= 3'h0;
			pd_q <= 1'b0;
		end
		else
		begin
			grp_q <= grp_d;
			pd_q <= pwr_down;
		end
	end

	// group pins and power-down flag from their flip-flops
	assign group_output_a = grp_q[0];
	assign group_output_b = grp_q[1];
	assign group_output_c = grp_q[2];
	assign channel_powered_down = pd_q;

	// status: live state of the block
	assign status = {1'b0, grp_q, pre_bypass, pd_q, div_running, div_out};

endmodule
`default_nettype wire

// file: tb/cdp_channel_assertions.sv
// port checker for the channel divider block
`timescale 1ns/100ps
`default_nettype none

module cdp_channel_checker
(
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic group_output_a,
	input wire logic group_output_b,
	input wire logic group_output_c,
	input wire logic channel_powered_down
);
	import cdp_pkg::*;
	logic acc;
	logic pw_ph;
	logic pw_val;

	// accepted address phase
	assign acc = hsel && hready && htrans[1];

	// remembers data of a power register write
	always_ff @(posedge clk)
	begin
		pw_ph <= !srst && acc && hwrite && haddr == 32'h0000066c;
		if (pw_ph)
			pw_val <= hwdata[2];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// ************************************************
	// checks
	// ************************************************
	ready_hold_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp) else $error("error response");
	rd_upper_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
	rd_unmap_a: assert property (acc && !hwrite && haddr == 32'h00000400 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	rd_stand_a: assert property (!acc |=> $stable(hrdata)) else $error("read data moved");
	pd_park_a: assert property (channel_powered_down [*3] |-> !(group_output_a || group_output_b || group_output_c))
		else $error("outputs active in power down");
	pd_track_a: assert property (pw_ph |-> ##[2:3] channel_powered_down == pw_val)
		else $error("power down flag wrong");
	grp_same_a: assert property (group_output_a == group_output_b && group_output_b == group_output_c)
		else $error("group outputs differ");
	cover property (pw_ph);
	cover property ($rose(group_output_a));
	cover property (acc && !hwrite);
endmodule

bind cdp_channel cdp_channel_checker cdp_channel_checker_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .group_output_a(group_output_a), .group_output_b(group_output_b),
	.group_output_c(group_output_c), .channel_powered_down(channel_powered_down));
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the channel divider block
`timescale 1ns/100ps
`default_nettype none
`include "cdp_params.svh"

module testbench;
	import cdp_pkg::*;
	logic clk = 0, srst = 1, hsel = 0, hwrite = 0, osc = 0, ext = 0, sync = 0, ext_run = 0, osc_run = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, m_val = 0;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, ga, gb, gc, pd, rd_ph = 0, m_v = 0;
	logic [31:0] exp_q[$];
	string nm_q[$];
	int error_cnt = 0, n_compared = 0;

	always #50 clk = ~clk;

	// source clocks toggle every clk while running
	always @(posedge clk)
	begin
		if (ext_run)
			ext <= ~ext;
		if (osc_run)
			osc <= ~osc;
	end

	cdp_channel cdp_channel_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .internal_oscillator(osc), .ext_clk_in(ext),
		.chip_sync(sync), .group_output_a(ga), .group_output_b(gb), .group_output_c(gc),
		.channel_powered_down(pd));

	// ************************************************
	// checking
	// ************************************************
	task chk(input logic [31:0] got, input logic [31:0] e, input string s);
		n_compared++;
		if (got !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", s, e, got);
		end
	endtask

	// takes the oldest note when a result appears
	always @(posedge clk)
		if ((rd_ph && hreadyout) || m_v)
			chk(rd_ph ? hrdata : m_val, exp_q.pop_front(), nm_q.pop_front());

	task report_and_stop;
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ************************************************
	// drivers
	// ************************************************
	task xfer(input logic [11:0] idx, input logic w, input logic [31:0] d, input logic [31:0] e);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {18'h0, idx, 2'h0};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		if (!w)
		begin
			exp_q.push_back(e);
			nm_q.push_back("read data");
		end
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_ph <= 0;
		hsel <= 0;
	endtask

	task note(input logic [31:0] v, input logic [31:0] e, input string s);
		exp_q.push_back(e);
		nm_q.push_back(s);
		@(negedge clk) m_val = v;
		m_v = 1;
		@(negedge clk) m_v = 0;
	endtask

	task rises(input int n, output int r);
		logic p;
		r = 0;
		p = ga;
		repeat (n)
		begin
			@(negedge clk);
			r += int'(ga && !p);
			p = ga;
		end
	endtask

	// measures period and high time of the group output
	task meas(input int per_e, input int hi_e);
		int per, hi_n;
		logic p;
		repeat (2 * per_e) @(negedge clk);
		p = ga;
		repeat (400)
		begin
			@(negedge clk);
			if (ga && !p)
				break;
			p = ga;
		end
		per = 0;
		hi_n = 1;
		p = 1;
		repeat (400)
		begin
			@(negedge clk);
			per++;
			if (ga && !p)
				break;
			hi_n += int'(ga);
			p = ga;
		end
		note(per, per_e, "period");
		note(hi_n, hi_e, "high time");
	endtask

	initial
	begin
		#(100 * 30000);
		error_cnt++;
		report_and_stop;
	end

	// ************************************************
	// tests
	// ************************************************
	initial
	begin
		logic [11:0] ix[5] = '{`CDP_IDX_DIV_CYCLES, `CDP_IDX_DIV_CTRL, `CDP_IDX_PWR_ROUTE, `CDP_IDX_PRESCALE, `CDP_IDX_SRC_SEL};
		logic [7:0] mk[5] = '{8'hff, 8'hff, 8'h07, 8'h07, 8'h03};
		logic [7:0] fv[6] = '{8'h70, 8'h60, 8'h30, 8'hf0, 8'h00, 8'h40};
		logic [7:0] c;
		int r, pp;
		void'($urandom(85));
		repeat (2) @(posedge clk);
		srst <= 0;
		for (int i = 0; i < 5; i++)
			xfer(ix[i], 0, 0, 0);
		xfer(12'h100, 1, 32'hff, 0);
		xfer(12'h100, 0, 0, 0);
		for (int i = 0; i < 5; i++)
		begin
			c = 8'($urandom);
			xfer(ix[i], 1, {24'h0, c}, 0);
			xfer(ix[i], 0, 0, {24'h0, c & mk[i]});
		end
		xfer(`CDP_IDX_DIV_CTRL, 1, 0, 0);
		xfer(`CDP_IDX_SRC_SEL, 1, 1, 0);
		ext_run <= 1;
		c = 8'($urandom) & 8'h33;
		pp = int'(c[7:4]) + int'(c[3:0]) + 2;
		for (int d = 0; d < 2; d++)
		begin
			xfer(`CDP_IDX_PWR_ROUTE, 1, d, 0);
			xfer(`CDP_IDX_DIV_CYCLES, 1, {24'h0, c}, 0);
			meas(pp * 2, (d == 1 ? int'(c[3:0]) + 1 : pp / 2) * 2);
		end
		xfer(`CDP_IDX_PWR_ROUTE, 1, 0, 0);
		xfer(`CDP_IDX_SRC_SEL, 1, 0, 0);
		for (int k = 0; k < 5; k++)
		begin
			xfer(`CDP_IDX_PRESCALE, 1, k, 0);
			meas(pp * (k + 2) * 2, (pp / 2) * (k + 2) * 2);
		end
		osc_run <= 1;
		xfer(`CDP_IDX_SRC_SEL, 1, 3, 0);
		meas(pp * 12, (pp / 2) * 12);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk) sync <= (i > 3);
			xfer(`CDP_IDX_DIV_CTRL, 1, {24'h0, fv[i]}, 0);
			repeat (8) @(negedge clk);
			rises(200, r);
			note(r != 0, i == 2 || i == 3 || i == 5, "toggling");
			if (i < 2)
			begin
				note(ga, fv[i][4], "forced level");
				xfer(`CDP_IDX_STATUS, 0, 0, fv[i][4] ? 32'h71 : 32'h00);
			end
		end
		@(posedge clk) sync <= 0;
		ext_run <= 0;
		osc_run <= 0;
		xfer(`CDP_IDX_PWR_ROUTE, 1, 2, 0);
		for (int j = 0; j < 4; j++)
		begin
			xfer(`CDP_IDX_SRC_SEL, 1, j < 2 ? 2 : 0, 0);
			osc <= !j[0];
			ext <= j[0];
			repeat (8) @(negedge clk);
			note({ga, gb, gc}, (j[1] ? j[0] : !j[0]) ? 3'h7 : 3'h0, "routed level");
		end
		ext_run <= 1;
		xfer(`CDP_IDX_PWR_ROUTE, 1, 4, 0);
		repeat (8) @(negedge clk);
		rises(100, r);
		note({pd, ga, gb, gc, r != 0}, 5'h10, "power down");
		xfer(`CDP_IDX_PWR_ROUTE, 1, 0, 0);
		repeat (8) @(negedge clk);
		rises(200, r);
		note({pd, r != 0}, 2'h1, "power up");
		report_and_stop;
	end
endmodule
`default_nettype wire
